//--- rtl/quad_timer_counter_capture.sv
// Behaviour
// RL1: four units, 8-bit count and match, tick increments
// RL2: plain mode needs capture, pair, pwm clear
// RL3: per-unit prescaler choices from clock select
// RL4: count equal match clears to zero, continues
// RL5: match sets unit match interrupt flag
// RL6: event pin a feeds unit 0, b unit 2
// RL7: event pins count only when port select set
// RL8: source keeps event edges at half clock rate
// RL9: match registers reset to zero
// RL10: interval is period x2 x ratio x (match+1)
// RL11: paired units form 16-bit timer, lower interrupt
// RL12: pairing needs upper select 11 and pair_a
// RL13: both pairs configured independently
// RL14: unit 0/2 match toggles compare output
// RL15: compare pin driven only when port select set
// RL16: capture mode chosen by unit capture select bit
// RL17: capture mode counts and matches like timer
// RL18: capture edge copies count, clears counter
// RL19: capture edge falling, rising or both
// RL20: capture edge also raises external interrupt
// RL21: capture mode reads capture at match address
// RL22: count_run low pauses and holds count
// RL23: restart one clears and runs, zero stops
// RL24: pin inputs synchronised and edge detected
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module quad_timer_counter_capture (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // axi4-lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // axi4-lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // external event inputs
  input  wire logic        event_pin_a,
  input  wire logic        event_pin_b,
  // capture edge inputs, one per unit
  input  wire logic [3:0]  capture_pin,
  // compare outputs
  output logic             compare_pin_unit0,
  output logic             compare_out_enable_unit0,
  output logic             compare_pin_unit2,
  output logic             compare_out_enable_unit2,
  // interrupt requests
  output logic [3:0]       match_interrupt_flag,
  output logic [3:0]       capture_irq
);
  // --------
  // state
  // --------
  typedef struct packed {
    logic [3:0][7:0] mode;      // mode_reg_unit0..3
    logic [3:0][7:0] match;     // match_value_unit0..3
    logic [3:0][7:0] capv;      // capture_value_unit0..3
    logic [3:0][7:0] cnt;       // count registers
    logic [3:0]      mflag;     // match flags
    logic [3:0]      cflag;     // capture edge flags
    logic [7:0]      edge_sel;  // two bits per capture pin
    logic [7:0]      port_function_select0;      // port_function_select0
    logic [7:0]      port_function_select1;      // port_function_select1
    logic [qtc_pkg::PRE_W-1:0] pre; // free prescaler
    logic [1:0]      ev_s1;     // event sync stage 1
    logic [1:0]      ev_s2;     // event sync stage 2
    logic [1:0]      ev_s3;     // event previous level
    logic [3:0]      cp_s1;     // capture sync stage 1
    logic [3:0]      cp_s2;     // capture sync stage 2
    logic [3:0]      cp_s3;     // capture previous level
    logic [1:0]      cmp;       // compare output levels
    logic            aw_got;    // write address held
    logic [7:0]      awa;       // held write address
    logic            w_got;     // write data held
    logic [7:0]      wd;        // held write data
    logic            ws;        // held low-lane strobe
    logic            bv;        // write response pending
    logic [1:0]      br;        // write response code
    logic            rv;        // read data pending
    logic [7:0]      rd;        // read data
    logic [1:0]      rr;        // read response code
  } state_t;

  state_t q_reg;   // registered state
  state_t q_next;  // next state

  // --------
  // helpers
  // --------
  // one tick each time the low k prescaler bits are all ones
  function automatic logic tick_of(
    input logic [qtc_pkg::PRE_W-1:0] pre,
    input logic [3:0]                k);
    logic [qtc_pkg::PRE_W-1:0] m;
    m = qtc_pkg::PRE_W'((13'h0001 << k) - 13'h0001);
    return (pre & m) == m;
  endfunction : tick_of

  // --------
  // bus handshakes
  // --------
  // channels stall while a response waits
  assign awready = ~q_reg.aw_got & ~q_reg.bv;
  assign wready  = ~q_reg.w_got & ~q_reg.bv;
  assign arready = ~q_reg.rv;
  assign bvalid  = q_reg.bv;
  assign bresp   = q_reg.br;
  assign rvalid  = q_reg.rv;
  assign rresp   = q_reg.rr;
  assign rdata   = {24'h000000, q_reg.rd};

  // --------
  // pins
  // --------
  assign compare_pin_unit0 = q_reg.cmp[0];
  assign compare_pin_unit2 = q_reg.cmp[1];
  // pin driven only while port select enables it
  assign compare_out_enable_unit0 =
    q_reg.port_function_select1[qtc_pkg::PORT_FUNCTION_SELECT1_CMP_BIT]; // RL15
  assign compare_out_enable_unit2 =
    q_reg.port_function_select1[qtc_pkg::PORT_FUNCTION_SELECT1_CMP_BIT+1]; // RL15
  assign match_interrupt_flag = q_reg.mflag; // RL5
  assign capture_irq          = q_reg.cflag; // RL20

  // --------
  // next-state logic
  // --------
  always_comb begin
    logic [1:0]  ev_rise;   // event rising edges
    logic [3:0]  cp_edge;   // qualified capture edges
    logic [3:0]  mset;      // match events this cycle
    logic [3:0]  cset;      // capture events this cycle
    logic [3:0]  restart;   // restart written per unit
    logic [3:0]  mclr;      // match flags cleared
    logic [3:0]  cclr;      // capture flags cleared
    logic [1:0]  tk;        // ticks of lower, upper unit
    logic [1:0]  run;       // run state of lower, upper
    logic [1:0]  capm;      // capture mode lower, upper
    logic [2:0]  slo;       // lower unit clock select
    logic [1:0]  shi;       // upper unit clock select
    logic        paired;    // pair runs as 16 bits
    logic [15:0] c16;       // paired count
    logic        aw_now;    // address taken now
    logic        w_now;     // data taken now
    logic        do_wr;     // write performed now
    logic [7:0]  wa;        // write address
    logic [7:0]  wv;        // write value
    logic        we;        // write strobe
    logic [7:0]  ra;        // aligned read address
    int          lo;        // lower unit index
    int          u;         // unit index
    ev_rise = '0;
    cp_edge = '0;
    mset    = '0;
    cset    = '0;
    restart = '0;
    mclr    = '0;
    cclr    = '0;
    tk      = '0;
    run     = '0;
    capm    = '0;
    slo     = '0;
    shi     = '0;
    paired  = 1'b0;
    c16     = '0;
    lo      = 0;
    u       = 0;
    ra      = '0;
    q_next  = q_reg;
    // synchronisers and edge detect, edges from stage 2 only
    q_next.ev_s1 = {event_pin_b, event_pin_a}; // RL24
    q_next.ev_s2 = q_reg.ev_s1;
    q_next.ev_s3 = q_reg.ev_s2;
    q_next.cp_s1 = capture_pin; // RL24
    q_next.cp_s2 = q_reg.cp_s1;
    q_next.cp_s3 = q_reg.cp_s2;
    // one count per rising edge; needs edges at most clk/2
    ev_rise = q_reg.ev_s2 & ~q_reg.ev_s3; // RL6 RL8 RL24
    for (int i = 0; i < 4; i++) begin
      // bit 0 enables falling, bit 1 rising, both for 11
      cp_edge[i] =
        (q_reg.edge_sel[2*i] & q_reg.cp_s3[i]
          & ~q_reg.cp_s2[i]) |
        (q_reg.edge_sel[2*i+1] & ~q_reg.cp_s3[i]
          & q_reg.cp_s2[i]); // RL19
    end
    cset = cp_edge; // RL20
    // free-running prescaler shared by all units
    q_next.pre = q_reg.pre + 12'h001;
    // counting, one pair of units per pass
    for (int p = 0; p < 2; p++) begin
      lo  = 2 * p;
      slo = q_reg.mode[lo][qtc_pkg::SEL_LO_MSB:qtc_pkg::SEL_LSB];
      shi = q_reg.mode[lo+1][qtc_pkg::SEL_HI_MSB:qtc_pkg::SEL_LSB];
      // lower unit: external events or its own divider
      if (slo == qtc_pkg::SEL_EXT) begin
        tk[0] = ev_rise[p]
          & q_reg.port_function_select0[qtc_pkg::PORT_FUNCTION_SELECT0_EVENT_BIT+p]; // RL6 RL7
      end else begin
        tk[0] = tick_of(q_reg.pre,
          qtc_pkg::DIV_LOG_LO[p][slo]); // RL3 RL10
      end
      // upper unit: own divider or lower unit's clock
      if (shi == qtc_pkg::SEL_CASCADE) begin
        tk[1] = tk[0];
      end else begin
        tk[1] = tick_of(q_reg.pre,
          qtc_pkg::DIV_LOG_HI[p][shi]); // RL3 RL10
      end
      // counting needs both run and restart bits high
      run[0] = q_reg.mode[lo][qtc_pkg::RUN_BIT]
        & q_reg.mode[lo][qtc_pkg::RESTART_BIT]; // RL22 RL23
      run[1] = q_reg.mode[lo+1][qtc_pkg::RUN_BIT]
        & q_reg.mode[lo+1][qtc_pkg::RESTART_BIT]; // RL22 RL23
      capm[0] = q_reg.mode[lo][qtc_pkg::CAP_LO_BIT]; // RL16
      capm[1] = q_reg.mode[lo+1][qtc_pkg::CAP_HI_BIT]; // RL16
      paired = q_reg.mode[lo+1][qtc_pkg::PAIR_BIT]
        & (shi == qtc_pkg::SEL_CASCADE); // RL12 RL13
      if (paired) begin
        // 16-bit timer on the lower unit's clock and run bits
        c16 = {q_reg.cnt[lo+1], q_reg.cnt[lo]};
        if (tk[0] && run[0]) begin
          if (c16 == {q_reg.match[lo+1], q_reg.match[lo]}) begin
            c16 = '0; // RL11
            mset[lo] = 1'b1; // RL11
            q_next.cmp[p] = ~q_reg.cmp[p]; // RL14
          end else begin
            c16 = c16 + 16'h0001; // RL11
          end
        end
        {q_next.cnt[lo+1], q_next.cnt[lo]} = c16;
      end else begin
        for (int h = 0; h < 2; h++) begin
          u = lo + h;
          // upper unit in pwm mode is not a timer here
          if (h == 0 || !q_reg.mode[u][qtc_pkg::PWM_BIT]) begin // RL2
            if (capm[h] && cp_edge[u]) begin
              // capture then clear, capture wins over tick
              q_next.capv[u] = q_reg.cnt[u]; // RL18
              q_next.cnt[u]  = '0; // RL18
            end else if (tk[h] && run[h]) begin
              if (q_reg.cnt[u] == q_reg.match[u]) begin
                q_next.cnt[u] = '0; // RL4 RL17
                mset[u] = 1'b1; // RL5 RL17
                if (h == 0) begin
                  q_next.cmp[p] = ~q_reg.cmp[p]; // RL14
                end
              end else begin
                q_next.cnt[u] = 8'(q_reg.cnt[u] + 8'h01); // RL1
              end
            end
          end
        end
      end
    end
    // bus write
    aw_now = awvalid & awready;
    w_now  = wvalid & wready;
    wa = q_reg.aw_got ? q_reg.awa : awaddr;
    wv = q_reg.w_got ? q_reg.wd : wdata[7:0];
    we = q_reg.w_got ? q_reg.ws : wstrb[0];
    do_wr = (q_reg.aw_got | aw_now) & (q_reg.w_got | w_now);
    if (aw_now) begin
      q_next.aw_got = 1'b1;
      q_next.awa    = awaddr;
    end
    if (w_now) begin
      q_next.w_got = 1'b1;
      q_next.wd    = wdata[7:0];
      q_next.ws    = wstrb[0];
    end
    if (do_wr) begin
      // both halves present: perform and answer
      q_next.aw_got = 1'b0;
      q_next.w_got  = 1'b0;
      q_next.bv     = 1'b1;
      q_next.br     = qtc_pkg::RESP_OKAY;
      wa = {wa[7:2], 2'b00};
      unique case (wa[7:4])
        qtc_pkg::REGION_MODE: begin
          if (we) begin
            q_next.mode[wa[3:2]] = wv;
            // a one clears the count, a zero stops it
            restart[wa[3:2]] = wv[qtc_pkg::RESTART_BIT]; // RL23
          end
        end
        qtc_pkg::REGION_MATCH: begin
          if (we) q_next.match[wa[3:2]] = wv;
        end
        qtc_pkg::REGION_COUNT: begin
          // counts are read only
        end
        default: begin
          if (wa == qtc_pkg::FLAG_OFS) begin
            mclr = we ? wv[3:0] : 4'h0;
            cclr = we ? wv[7:4] : 4'h0;
          end else if (wa == qtc_pkg::EDGE_SEL_OFS) begin
            if (we) q_next.edge_sel = wv;
          end else if (wa == qtc_pkg::PORT_FUNCTION_SELECT1_OFS) begin
            if (we) q_next.port_function_select1 = wv;
          end else if (wa == qtc_pkg::PORT_FUNCTION_SELECT0_OFS) begin
            if (we) q_next.port_function_select0 = wv;
          end else begin
            q_next.br = qtc_pkg::RESP_DECERR;
          end
        end
      endcase
    end
    if (q_reg.bv && bready) begin
      q_next.bv = 1'b0;
    end
    // restart clears after counting so it always wins
    for (int i = 0; i < 4; i++) begin
      if (restart[i]) begin
        q_next.cnt[i] = '0; // RL23
      end
    end
    // lower unit restart clears a whole 16-bit pair
    for (int p = 0; p < 2; p++) begin
      if (restart[2*p] && q_reg.mode[2*p+1][qtc_pkg::PAIR_BIT]
          && q_reg.mode[2*p+1][qtc_pkg::SEL_HI_MSB:
                              qtc_pkg::SEL_LSB]
             == qtc_pkg::SEL_CASCADE) begin
        q_next.cnt[2*p+1] = '0; // RL11 RL23
      end
    end
    // flags: a new event beats a clear in the same cycle
    q_next.mflag = (q_reg.mflag & ~mclr) | mset; // RL5
    q_next.cflag = (q_reg.cflag & ~cclr) | cset; // RL20
    // bus read
    if (arvalid && arready) begin
      ra = {araddr[7:2], 2'b00};
      q_next.rv = 1'b1;
      q_next.rr = qtc_pkg::RESP_OKAY;
      q_next.rd = '0;
      unique case (ra[7:4])
        qtc_pkg::REGION_MODE: begin
          q_next.rd = q_reg.mode[ra[3:2]];
        end
        qtc_pkg::REGION_MATCH: begin
          // capture mode opens the capture register here
          u = int'(ra[3:2]);
          q_next.rd = q_reg.mode[u][(u % 2 == 0) ?
            qtc_pkg::CAP_LO_BIT : qtc_pkg::CAP_HI_BIT]
            ? q_reg.capv[u] : q_reg.match[u]; // RL21
        end
        qtc_pkg::REGION_COUNT: begin
          q_next.rd = q_reg.cnt[ra[3:2]];
        end
        default: begin
          if (ra == qtc_pkg::FLAG_OFS) begin
            q_next.rd = {q_reg.cflag, q_reg.mflag};
          end else if (ra == qtc_pkg::EDGE_SEL_OFS) begin
            q_next.rd = q_reg.edge_sel;
          end else if (ra == qtc_pkg::PORT_FUNCTION_SELECT1_OFS) begin
            q_next.rd = q_reg.port_function_select1;
          end else if (ra == qtc_pkg::PORT_FUNCTION_SELECT0_OFS) begin
            q_next.rd = q_reg.port_function_select0;
          end else begin
            q_next.rr = qtc_pkg::RESP_DECERR;
          end
        end
      endcase
    end else if (q_reg.rv && rready) begin
      q_next.rv = 1'b0;
    end
  end

  // --------
  // state register
  // --------
  // synchronous reset clears all state, match registers included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0; // RL9
    end else begin
      q_reg <= q_next;
    end
  end
endmodule : quad_timer_counter_capture
`default_nettype wire

//--- include/qtc_pkg.sv
`default_nettype none
package qtc_pkg;
  // --------
  // register map (byte addresses, one 32-bit word each)
  // --------
  localparam logic [3:0] REGION_MODE   = 4'h0; // 0x00..0x0c mode
  localparam logic [3:0] REGION_MATCH  = 4'h1; // 0x10..0x1c match
  localparam logic [3:0] REGION_COUNT  = 4'h3; // 0x30..0x3c count
  localparam logic [7:0] FLAG_OFS      = 8'h20; // w1c event flags
  localparam logic [7:0] EDGE_SEL_OFS  = 8'h24; // edge_select_reg
  localparam logic [7:0] PORT_FUNCTION_SELECT1_OFS      = 8'hf4; // port select 1
  localparam logic [7:0] PORT_FUNCTION_SELECT0_OFS      = 8'hf8; // port select 0
  localparam logic [7:0] REG_RESET     = 8'h00; // every register
  // --------
  // mode register fields
  // --------
  localparam int RESTART_BIT = 0; // count_restart
  localparam int RUN_BIT     = 1; // count_run
  localparam int SEL_LSB     = 2; // clock select low bit
  localparam int SEL_LO_MSB  = 4; // 3-bit select, units 0/2
  localparam int SEL_HI_MSB  = 3; // 2-bit select, units 1/3
  localparam int CAP_LO_BIT  = 5; // capture select, units 0/2
  localparam int CAP_HI_BIT  = 4; // capture select, units 1/3
  localparam int PWM_BIT     = 5; // pwm enable, units 1/3
  localparam int PAIR_BIT    = 6; // pair_a, units 1/3
  localparam logic [2:0] SEL_EXT     = 3'h7; // external events
  localparam logic [1:0] SEL_CASCADE = 2'h3; // use lower clock
  // --------
  // port select bits
  // --------
  localparam int PORT_FUNCTION_SELECT0_EVENT_BIT = 4; // bit 4 pin a, bit 5 pin b
  localparam int PORT_FUNCTION_SELECT1_CMP_BIT   = 0; // bit 0 unit 0, bit 1 unit 2
  // --------
  // prescaler: log2 of (2 x divide ratio) per select code
  // --------
  localparam int PRE_W = 12;
  localparam logic [1:0][7:0][3:0] DIV_LOG_LO = {
    {4'h0, 4'hb, 4'h9, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2},
    {4'h0, 4'hc, 4'ha, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2}};
  localparam logic [1:0][3:0][3:0] DIV_LOG_HI = {
    {4'h0, 4'h5, 4'h3, 4'h1},
    {4'h0, 4'h4, 4'h2, 4'h1}};
  // --------
  // bus responses
  // --------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : qtc_pkg
`default_nettype wire

//--- dv/qtc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module qtc_pins_model (
  // clock
  input  wire logic aclk,
  // pins toward the block
  output logic       event_pin_a,
  output logic       event_pin_b,
  output logic [3:0] capture_pin
);
  // pins idle low at time zero
  initial begin
    event_pin_a = 1'b0;
    event_pin_b = 1'b0;
    capture_pin = 4'h0;
  end
  // n rising edges, each level held two cycles
  task automatic events(input logic sel_b, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (2) @(posedge aclk);
      if (sel_b) event_pin_b <= ~event_pin_b;
      else event_pin_a <= ~event_pin_a;
    end
  endtask : events
  // move one capture line, then give the synchroniser time
  task automatic cap_level(input int u, input logic lvl);
    @(posedge aclk);
    capture_pin[u] <= lvl;
    repeat (6) @(posedge aclk);
  endtask : cap_level
endmodule : qtc_pins_model
`default_nettype wire

//--- dv/quad_timer_counter_capture_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module quad_timer_counter_capture_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // timer outputs
  input wire logic        compare_pin_unit0,
  input wire logic        compare_pin_unit2,
  input wire logic [3:0]  match_interrupt_flag,
  input wire logic [3:0]  capture_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // read address taken
  sequence rd_taken;
    arvalid && arready;
  endsequence
  a_write_answer: assert property (wr_taken |=> bvalid)
    else $error("write answer late");
  a_read_answer: assert property (rd_taken |=> rvalid)
    else $error("read answer late");
  a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  a_flag_clear:
    assert property ($fell(match_interrupt_flag[0]) |-> bvalid)
    else $error("match flag dropped without write");
  a_cap_clear:
    assert property ($fell(capture_irq[0]) |-> bvalid)
    else $error("capture flag dropped without write");
  a_cmp0_toggle:
    assert property ($changed(compare_pin_unit0) |-> match_interrupt_flag[0])
    else $error("compare 0 moved without match");
  a_cmp2_toggle:
    assert property ($changed(compare_pin_unit2) |-> match_interrupt_flag[2])
    else $error("compare 2 moved without match");
endmodule : quad_timer_counter_capture_asserts
`default_nettype wire

//--- dv/test_quad_timer_counter_capture.sv
`timescale 1ns/100ps
`default_nettype none
module test_quad_timer_counter_capture;
  // --------
  // signals
  // --------
  logic        aclk, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  logic        event_pin_a, event_pin_b;
  logic [3:0]  capture_pin, match_interrupt_flag, capture_irq;
  logic        compare_pin_unit0, compare_pin_unit2;
  logic        compare_out_enable_unit0, compare_out_enable_unit2;
  int          num_errors = 0, checks_done = 0, cyc = 0;
  // divide ratio per unit and select code
  localparam int DIVS [4][7] = '{'{2, 4, 8, 32, 128, 512, 2048},
    '{1, 2, 8, 0, 0, 0, 0}, '{2, 4, 8, 16, 64, 256, 1024},
    '{1, 4, 16, 0, 0, 0, 0}};
  localparam int NCODE [4] = '{7, 3, 7, 3};
  // block, far-side pins
  quad_timer_counter_capture i_dut (.aclk, .aresetn, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .event_pin_a, .event_pin_b, .capture_pin,
    .compare_pin_unit0, .compare_out_enable_unit0, .compare_pin_unit2,
    .compare_out_enable_unit2, .match_interrupt_flag, .capture_irq);
  qtc_pins_model i_pins (.aclk, .event_pin_a, .event_pin_b,
    .capture_pin);
  // clock and cycle count
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  // --------
  // helpers
  // --------
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // one comparison of a design value
  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // a wait that ran out
  task automatic hang;
    num_errors++;
    end_sim();
  endtask : hang
  // bus write, address and data offered together
  task automatic wr(input int a, input int d, output logic [1:0] rs);
    bit pa, pw, pb;
    int n;
    @(posedge aclk);
    awaddr  <= 8'(a);
    wdata   <= 32'(d & 255);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    {pa, pw, pb, n} = {3'b111, 32'd0};
    while (pb) begin
      @(posedge aclk);
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 0;
      end
      // ready follows the answer so that its hold is seen
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        pb = 0;
      end else if (bvalid) begin
        bready <= 1'b1;
      end
      if (++n > 50) hang();
    end
  endtask : wr
  // bus read
  task automatic rd(input int a, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr  <= 8'(a);
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      // ready follows the data so that its hold is seen
      if (rvalid && !rready) rready <= 1'b1;
      if (++n > 50) hang();
    end while (!(rvalid && rready));
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // clear one match flag, wait until it rises again
  task automatic rise(input int b, output int t, output logic c);
    int n;
    wr(8'h20, 1 << b, r);
    n = 0;
    do begin
      @(posedge aclk);
      if (++n > 20000) hang();
    end while (match_interrupt_flag[b] !== 1'b1);
    t = cyc;
    c = (b == 2) ? compare_pin_unit2 : compare_pin_unit0;
  endtask : rise
  // steady match period and whether the compare pin flipped
  task automatic meas(input int b, output int p, output logic f);
    int t0, t1, t2;
    logic c0, c1, c2;
    rise(b, t0, c0);
    rise(b, t1, c1);
    rise(b, t2, c2);
    p = t2 - t1;
    f = c1 ^ c2;
  endtask : meas
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // --------
  // scenarios
  // --------
  task automatic t_reset;
    logic [31:0] d;
    for (int u = 0; u < 4; u++) begin
      rd(16 + 4 * u, d, r);
      chk("match reset", 0, d);
      rd(4 * u, d, r);
      chk("mode reset", 0, d);
    end
    chk("cmp enable", 0, compare_out_enable_unit0);
    rd(8'h80, d, r);
    chk("unmapped rd", qtc_pkg::RESP_DECERR, r);
    wr(8'h80, 8'h5a, r);
    chk("unmapped wr", qtc_pkg::RESP_DECERR, r);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_prescale;
    int p, m;
    logic f;
    wr(qtc_pkg::PORT_FUNCTION_SELECT1_OFS, 8'h03, r);
    chk("cmp enable", 1, compare_out_enable_unit2);
    for (int u = 0; u < 4; u++)
      for (int k = 0; k < NCODE[u]; k++) begin
        m = (DIVS[u][k] >= 64) ? 0 : 7;
        wr(16 + 4 * u, m, r);
        wr(4 * u, (k << 2) | 3, r);
        meas(u, p, f);
        chk("period", 2 * DIVS[u][k] * (m + 1), p);
        if (u % 2 == 0) chk("cmp toggle", 1, f);
        wr(4 * u, 0, r);
      end
    $display("t_prescale done");
  endtask : t_prescale
  task automatic t_pair;
    int p;
    logic f;
    logic [31:0] d;
    wr(8'h10, 8'h2b, r);
    wr(8'h14, 8'h01, r);
    wr(8'h04, 8'h4c, r);
    wr(8'h1c, 8'h07, r);
    wr(8'h0c, 8'h03, r);
    wr(8'h00, 8'h03, r);
    wr(8'h20, 8'h0f, r);
    meas(0, p, f);
    chk("pair period", 1200, p);
    chk("upper flag", 0, match_interrupt_flag[1]);
    chk("other pair", 1, match_interrupt_flag[3]);
    // upper unit with pwm enable must not count
    wr(8'h14, 8'hff, r);
    wr(8'h04, 8'h23, r);
    repeat (20) @(posedge aclk);
    rd(8'h34, d, r);
    chk("pwm holds", 0, d);
    for (int u = 0; u < 4; u++) wr(4 * u, 0, r);
    $display("t_pair done");
  endtask : t_pair
  task automatic t_events;
    logic [31:0] d;
    for (int u = 0; u < 4; u += 2) begin
      wr(16 + 4 * u, 8'hff, r);
      wr(qtc_pkg::PORT_FUNCTION_SELECT0_OFS, 0, r);
      wr(4 * u, 8'h1f, r);
      i_pins.events(u == 2, 5);
      repeat (6) @(posedge aclk);
      rd(48 + 4 * u, d, r);
      chk("gated count", 0, d);
      wr(qtc_pkg::PORT_FUNCTION_SELECT0_OFS, 8'h30, r);
      i_pins.events(u == 2, 5);
      repeat (6) @(posedge aclk);
      rd(48 + 4 * u, d, r);
      chk("event count", 5, d);
    end
    $display("t_events done");
  endtask : t_events
  task automatic t_capture;
    logic [31:0] c0, d;
    int p;
    logic f;
    wr(8'h10, 8'h03, r);
    wr(8'h24, 8'h02, r);
    wr(8'h00, 8'h23, r);
    meas(0, p, f);
    chk("capture period", 16, p);
    wr(8'h10, 8'hff, r);
    wr(8'h00, 8'h23, r);
    repeat (40) @(posedge aclk);
    wr(8'h00, 8'h22, r);
    rd(8'h30, c0, r);
    repeat (20) @(posedge aclk);
    rd(8'h30, d, r);
    chk("held count", c0, d);
    wr(8'h20, 8'hf0, r);
    i_pins.cap_level(0, 1'b1);
    chk("capture irq", 1, capture_irq[0]);
    rd(8'h10, d, r);
    chk("captured", c0, d);
    rd(8'h30, d, r);
    chk("cleared", 0, d);
    i_pins.cap_level(0, 1'b0);
    wr(8'h00, 8'h02, r);
    rd(8'h10, d, r);
    chk("match back", 8'hff, d);
    for (int s = 0; s < 4; s++) begin
      wr(8'h24, s << 2, r);
      wr(8'h20, 8'hf0, r);
      i_pins.cap_level(1, 1'b1);
      chk("rise seen", s[1], capture_irq[1]);
      wr(8'h20, 8'hf0, r);
      i_pins.cap_level(1, 1'b0);
      chk("fall seen", s[0], capture_irq[1]);
    end
    $display("t_capture done");
  endtask : t_capture
  // main sequence
  initial begin
    do_reset();
    t_reset();
    t_prescale();
    wr(8'h10, 5, r);
    wr(8'h00, 3, r);
    do_reset();
    t_reset();
    t_pair();
    t_events();
    t_capture();
    end_sim();
  end
endmodule : test_quad_timer_counter_capture
bind quad_timer_counter_capture quad_timer_counter_capture_asserts
  i_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
  .rdata, .compare_pin_unit0, .compare_pin_unit2,
  .match_interrupt_flag, .capture_irq);
`default_nettype wire
